// ---- shared/lfds_pkg.sv ----
// Behaviour
// RQ1 - code 1000 starts interval every 2048 periods
// RQ2 - code 1001 starts interval every 4096 periods
// RQ3 - codes 1010 and up: detector always on
// RQ4 - codes 0100-0111: 128 to 1024, doubling
// RQ5 - each interval opens ON window, selected length
// RQ6 - ON is net; 2 ms warm-up precedes; the first start after reset gets none and goes straight from off to ON
// RQ7 - carrier mode: off early when evaluation done
// RQ8 - data mode: hold on until end/error/timeout
// RQ9 - reset clears ON-time field; field readable, writable
// RQ10 - ON code 0000 gives one oscillator cycle
// RQ11 - each higher ON code doubles, up to 1024
package lfds_pkg;

  // clock and oscillator timing
  localparam int MCLK_PERIOD_NS = 4;         // 250 MHz system clock
  localparam int LFO_PERIOD_MS  = 1;         // nominal oscillator period
  localparam int LFO_PERIOD_NS  = LFO_PERIOD_MS * 1000000;
  localparam int LFO_DIV        = LFO_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int STARTUP_MS     = 2;         // detector warm-up time
  // warm-up in oscillator periods, rounded up
  localparam int STARTUP_TICKS_I =
    (STARTUP_MS + LFO_PERIOD_MS - 1) / LFO_PERIOD_MS;

  // field layout
  localparam int SEL_W  = 4;                 // width of both select fields
  localparam int IVAL_W = 13;                // holds up to 4096
  localparam int ON_W   = 11;                // holds up to 1024

  localparam logic [IVAL_W-1:0] STARTUP_TICKS = IVAL_W'(STARTUP_TICKS_I);

  // interval select codes
  localparam logic [SEL_W-1:0]  IVAL_BASE_CODE = 4'h4;
  localparam logic [SEL_W-1:0]  IVAL_TOP_CODE  = 4'h9;
  localparam logic [SEL_W-1:0]  IVAL_CONT_CODE = 4'hA;
  localparam logic [IVAL_W-1:0] IVAL_BASE_LEN  = 13'h0080;
  localparam logic [IVAL_W-1:0] IVAL_TOP_LEN   = 13'h1000;

  // on-time select codes
  localparam logic [SEL_W-1:0]  ON_MAX_CODE    = 4'hA;
  localparam logic [ON_W-1:0]   ON_MAX_LEN     = 11'h400;
  localparam logic [ON_W-1:0]   ON_UNIT_LEN    = 11'h001;

  // reset values
  localparam logic [SEL_W-1:0]  IVAL_RST       = 4'h0;
  localparam logic [SEL_W-1:0]  ON_RST         = 4'h0;

  // both select fields travel together
  typedef struct packed {
    logic [SEL_W-1:0] ival;                  // sample_interval_select
    logic [SEL_W-1:0] on;                    // sample_on_time_select
  } lfds_cfg_t;

  // scheduler states, one-hot
  typedef enum logic [4:0] {
    ST_OFF  = 5'h01,
    ST_WARM = 5'h02,
    ST_ON   = 5'h04,
    ST_HOLD = 5'h08,
    ST_CONT = 5'h10
  } lfds_state_t;

endpackage : lfds_pkg

// ---- rtl/lfds_tick.sv ----
`timescale 1ns/1ps
// divides the system clock into one pulse per oscillator period
module lfds_tick
  import lfds_pkg::*;
#(
  parameter int DIV = LFO_DIV                // system cycles per period
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // period pulse
  output logic      tick_out
);

  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;                      // cycles within period
  logic [CW-1:0] cnt_nxt;
  logic          tick_r;                     // registered pulse
  logic          tick_nxt;

  //////////////////////////////////////////////////////////////////////
  // next count and pulse at the period end
  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + CW'(1);
    if (cnt_r == LAST) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;

endmodule : lfds_tick

// ---- rtl/lfds_sched.sv ----
`timescale 1ns/1ps
// duty-cycle scheduler for the low-frequency wake-up detector
module lfds_sched
  import lfds_pkg::*;
#(
  parameter int LFO_DIV_P = LFO_DIV          // cycles per oscillator period
) (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // configuration write and readback
  input  wire logic       cfg_wr_in,
  input  wire lfds_cfg_t  cfg_in,
  output lfds_cfg_t       cfg_out,
  // receiver mode and events
  input  wire logic       carrier_mode_select_in,
  input  wire logic       carrier_eval_done_in,
  input  wire logic       signal_detected_in,
  input  wire logic       msg_end_in,
  input  wire logic       rx_error_in,
  input  wire logic       rx_timeout_in,
  // detector control
  output logic            det_power_out,
  output logic            sample_window_out,
  output logic            interval_start_out
);

  //////////////////////////////////////////////////////////////////////
  // decoding, used by the interval and window counters

  // interval length in oscillator periods
  function automatic logic [IVAL_W-1:0] ival_len(input logic [SEL_W-1:0] c);
    if (c < IVAL_BASE_CODE)
      return IVAL_BASE_LEN;                  // lower codes lie elsewhere
    else if (c > IVAL_TOP_CODE)
      return IVAL_TOP_LEN;
    else
      return IVAL_W'(IVAL_BASE_LEN << (c - IVAL_BASE_CODE)); // RQ4
  endfunction : ival_len

  // on window length in oscillator periods
  function automatic logic [ON_W-1:0] on_len(input logic [SEL_W-1:0] c);
    if (c > ON_MAX_CODE)
      return ON_MAX_LEN;                     // saturate unused codes
    else
      return ON_W'(ON_UNIT_LEN << c);        // RQ11
  endfunction : on_len

  //////////////////////////////////////////////////////////////////////
  // declarations
  logic                tick;                 // one per oscillator period
  lfds_cfg_t           cfg_r;                // select fields
  lfds_cfg_t           cfg_nxt;
  lfds_state_t         st_r;                 // scheduler state
  lfds_state_t         st_nxt;
  logic [IVAL_W-1:0]   ic_r;                 // periods to next start
  logic [IVAL_W-1:0]   ic_nxt;
  logic [ON_W-1:0]     oc_r;                 // periods left in window
  logic [ON_W-1:0]     oc_nxt;
  logic                start_r;              // interval start pulse
  logic                start;
  logic                cont;                 // continuous mode
  logic                hold_end;             // data frame finished
  lfds_state_t         idle_st;              // where a window falls back

  lfds_tick #(
    .DIV      (LFO_DIV_P)
  ) u_tick (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .tick_out (tick)
  );

  //////////////////////////////////////////////////////////////////////
  // configuration fields
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_wr_in)
      cfg_nxt = cfg_in;                      // RQ9
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in)
      cfg_r <= '{ival: IVAL_RST, on: ON_RST}; // RQ9
    else
      cfg_r <= cfg_nxt;
  end

  assign cfg_out = cfg_r;                    // RQ9

  //////////////////////////////////////////////////////////////////////
  // interval and window counters
  assign cont     = (cfg_r.ival >= IVAL_CONT_CODE); // RQ3
  assign hold_end = msg_end_in | rx_error_in | rx_timeout_in;
  // warm-up starts early so the window itself is all sampling time
  assign idle_st  = (ic_nxt < STARTUP_TICKS) ? ST_WARM : ST_OFF; // RQ6

  always_comb begin
    ic_nxt = ic_r;
    oc_nxt = oc_r;
    start  = 1'b0;
    if (cfg_wr_in) begin
      // a new setting restarts the interval from its full length
      ic_nxt = ival_len(cfg_in.ival) - IVAL_W'(1);
    end else if (tick) begin
      if (ic_r == '0) begin
        start  = 1'b1;                       // RQ1 RQ2 RQ4
        ic_nxt = ival_len(cfg_r.ival) - IVAL_W'(1);
        oc_nxt = on_len(cfg_r.on);           // RQ5 RQ10 RQ11
      end else begin
        ic_nxt = ic_r - IVAL_W'(1);
        if (oc_r != '0)
          oc_nxt = oc_r - ON_W'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // scheduler state
  always_comb begin
    st_nxt = st_r;
    if (cfg_wr_in) begin
      st_nxt = ST_OFF;
    end else begin
      unique case (st_r)
        ST_CONT: begin
          if (!cont)
            st_nxt = idle_st;
        end
        ST_OFF, ST_WARM: begin
          if (cont)
            st_nxt = ST_CONT;                // RQ3
          else if (start)
            st_nxt = ST_ON;                  // RQ5
          else if (tick && ic_r == STARTUP_TICKS)
            st_nxt = ST_WARM;                // RQ6
        end
        ST_ON: begin
          if (cont)
            st_nxt = ST_CONT;
          else if (carrier_mode_select_in && carrier_eval_done_in)
            st_nxt = idle_st;                // RQ7
          else if (!carrier_mode_select_in && signal_detected_in)
            st_nxt = ST_HOLD;                // RQ8
          else if (start)
            st_nxt = ST_ON;                  // window overlaps next start
          else if (tick && oc_r == ON_UNIT_LEN)
            st_nxt = idle_st;                // RQ5
        end
        ST_HOLD: begin
          // the message owns the detector; starts are not honoured
          if (cont)
            st_nxt = ST_CONT;
          else if (hold_end)
            st_nxt = idle_st;                // RQ8
        end
        default: st_nxt = ST_OFF;            // illegal one-hot code
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r    <= ST_OFF;
      ic_r    <= '0;
      oc_r    <= '0;
      start_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      ic_r    <= ic_nxt;
      oc_r    <= oc_nxt;
      start_r <= start;
    end
  end

  // outputs straight from state flops
  assign det_power_out      = (st_r != ST_OFF);
  assign sample_window_out  = (st_r == ST_ON) || (st_r == ST_HOLD) ||
                              (st_r == ST_CONT);
  assign interval_start_out = start_r;

  //////////////////////////////////////////////////////////////////////
  // checks: spacing helper counts periods between starts
  logic [IVAL_W-1:0] gap_r;                  // ticks since last start
  logic              seen_r;                 // a full interval observed
  logic [SEL_W-1:0]  ival_q_r;               // code at last start

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_r    <= '0;
      seen_r   <= 1'b0;
      ival_q_r <= '0;
    end else begin
      if (cfg_wr_in) begin
        gap_r  <= '0;
        seen_r <= 1'b0;
      end else if (start) begin
        gap_r    <= '0;
        seen_r   <= 1'b1;
        ival_q_r <= cfg_r.ival;
      end else if (tick) begin
        gap_r <= gap_r + IVAL_W'(1);
      end
    end
  end

  property p_rq1;
    @(posedge mclk_in) disable iff (rst_in)
    start && seen_r && cfg_r.ival == 4'h8 && ival_q_r == 4'h8
      |-> gap_r == 13'h07FF;
  endproperty
  a_rq1: assert property (p_rq1) else $error("interval not 2048"); // RQ1

  property p_rq2;
    @(posedge mclk_in) disable iff (rst_in)
    start && seen_r && cfg_r.ival == 4'h9 && ival_q_r == 4'h9
      |-> gap_r == 13'h0FFF;
  endproperty
  a_rq2: assert property (p_rq2) else $error("interval not 4096"); // RQ2

  property p_rq3;
    @(posedge mclk_in) disable iff (rst_in)
    cont && !cfg_wr_in ##1 cont |-> det_power_out && sample_window_out;
  endproperty
  a_rq3: assert property (p_rq3) else $error("not continuous"); // RQ3

  property p_rq4;
    @(posedge mclk_in) disable iff (rst_in)
    start && seen_r && cfg_r.ival == ival_q_r && cfg_r.ival >= 4'h4
      && cfg_r.ival <= 4'h7
      |-> gap_r == IVAL_W'((13'h0080 << (cfg_r.ival - 4'h4)) - 13'h0001);
  endproperty
  a_rq4: assert property (p_rq4) else $error("bad low interval"); // RQ4

  property p_rq5;
    @(posedge mclk_in) disable iff (rst_in)
    start && !cont && !cfg_wr_in && st_r != ST_HOLD
      && !(st_r == ST_ON && carrier_mode_select_in && carrier_eval_done_in)
      |=> sample_window_out && interval_start_out;
  endproperty
  a_rq5: assert property (p_rq5) else $error("window not opened"); // RQ5

  property p_rq6;
    @(posedge mclk_in) disable iff (rst_in)
    // a start from rest must find the detector already warming
    start && seen_r && !cont && st_r != ST_ON && st_r != ST_HOLD
      |-> st_r == ST_WARM && det_power_out && !sample_window_out;
  endproperty
  a_rq6: assert property (p_rq6) else $error("no warm-up before start"); // RQ6

  property p_rq7;
    @(posedge mclk_in) disable iff (rst_in)
    st_r == ST_ON && carrier_mode_select_in && carrier_eval_done_in
      && !cont && !cfg_wr_in |=> !sample_window_out;
  endproperty
  a_rq7: assert property (p_rq7) else $error("no early off"); // RQ7

  property p_rq8;
    @(posedge mclk_in) disable iff (rst_in)
    st_r == ST_HOLD && !hold_end && !cfg_wr_in |=> sample_window_out;
  endproperty
  a_rq8: assert property (p_rq8) else $error("hold dropped"); // RQ8

  property p_rq9;
    @(posedge mclk_in) disable iff (rst_in)
    cfg_wr_in |=> cfg_out == $past(cfg_in);
  endproperty
  a_rq9: assert property (p_rq9) else $error("field not stored"); // RQ9

  property p_rq10;
    @(posedge mclk_in) disable iff (rst_in)
    start && cfg_r.on == 4'h0 |=> oc_r == 11'h001;
  endproperty
  a_rq10: assert property (p_rq10) else $error("code 0 not 1"); // RQ10

  property p_rq11;
    @(posedge mclk_in) disable iff (rst_in)
    start && cfg_r.on <= 4'hA |=> oc_r == (11'h001 << $past(cfg_r.on));
  endproperty
  a_rq11: assert property (p_rq11) else $error("on length wrong"); // RQ11

  c_early: cover property (@(posedge mclk_in) disable iff (rst_in)
    st_r == ST_ON && carrier_mode_select_in && carrier_eval_done_in
      ##1 (st_r == ST_WARM || st_r == ST_OFF));
  c_hold: cover property (@(posedge mclk_in) disable iff (rst_in)
    st_r == ST_HOLD ##1 st_r != ST_HOLD);
  c_cont: cover property (@(posedge mclk_in) disable iff (rst_in)
    st_r == ST_CONT);

endmodule : lfds_sched

// ---- dv/lfds_sched_test.sv ----
`timescale 1ns/1ps
module lfds_sched_test;
  import lfds_pkg::*;

  localparam int DIV   = 4;       // short oscillator period keeps run small
  localparam int LIMIT = 90000;   // cycle ceiling, run needs about 72000

  // one ordinary case: codes in, interval and window cycles out
  typedef struct packed {
    logic [3:0]  ival;
    logic [3:0]  on;
    logic [31:0] per;
    logic [31:0] win;
  } lfds_row_t;

  logic       mclk_in, rst_in, cfg_wr_in;
  lfds_cfg_t  cfg_in, cfg_out;
  logic       carrier_mode_select_in, carrier_eval_done_in;
  logic       signal_detected_in, msg_end_in, rx_error_in, rx_timeout_in;
  logic       det_power_out, sample_window_out, interval_start_out;
  int         bad_count, comparisons, cycles, warm, win, per, hi, st;
  bit         open;
  lfds_row_t  rows [6];

  lfds_sched #(.LFO_DIV_P(DIV)) DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in),
    .cfg_in(cfg_in), .cfg_out(cfg_out),
    .carrier_mode_select_in(carrier_mode_select_in),
    .carrier_eval_done_in(carrier_eval_done_in),
    .signal_detected_in(signal_detected_in), .msg_end_in(msg_end_in),
    .rx_error_in(rx_error_in), .rx_timeout_in(rx_timeout_in),
    .det_power_out(det_power_out), .sample_window_out(sample_window_out),
    .interval_start_out(interval_start_out));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  // a stuck wait must still end in the verdict
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, drive and wait helpers
  task chk_num(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_num

  task chk_cfg(input lfds_cfg_t got, input lfds_cfg_t exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cfg

  // both fields go in one strobe; readback follows one cycle later
  task write_cfg(input logic [3:0] iv, input logic [3:0] on);
    @(posedge mclk_in);
    cfg_wr_in <= 1'b1;
    cfg_in    <= {iv, on};
    @(posedge mclk_in);
    cfg_wr_in <= 1'b0;
    @(negedge mclk_in);
    chk_cfg(cfg_out, {iv, on});
  endtask : write_cfg

  // bounded wait for a start; warm counts powered cycles before window
  task wait_start();
    int n;
    n = 0;
    warm = 0;
    forever begin
      @(negedge mclk_in);
      n++;
      if (interval_start_out === 1'b1 || n >= 20000) break;
      if (det_power_out === 1'b1 && sample_window_out !== 1'b1) warm++;
      else warm = 0;
    end
    if (n >= 20000) chk_num(32'h0, 32'h1);
  endtask : wait_start

  // pulse one event input for a single cycle
  task pulse(input int which);
    @(posedge mclk_in);
    case (which)
      0: msg_end_in <= 1'b1;
      1: rx_error_in <= 1'b1;
      2: rx_timeout_in <= 1'b1;
      3: signal_detected_in <= 1'b1;
      default: carrier_eval_done_in <= 1'b1;
    endcase
    @(posedge mclk_in);
    {msg_end_in, rx_error_in, rx_timeout_in} <= 3'h0;
    {signal_detected_in, carrier_eval_done_in} <= 2'h0;
  endtask : pulse

  task print_verdict();
    $display("TB: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rows[0] = {4'h4, 4'h0, 32'h0000_0200, 32'h0000_0004};
    rows[1] = {4'h5, 4'h1, 32'h0000_0400, 32'h0000_0008};
    rows[2] = {4'h6, 4'h2, 32'h0000_0800, 32'h0000_0010};
    rows[3] = {4'h7, 4'h4, 32'h0000_1000, 32'h0000_0040};
    rows[4] = {4'h8, 4'h7, 32'h0000_2000, 32'h0000_0200};
    rows[5] = {4'h9, 4'hF, 32'h0000_4000, 32'h0000_1000};
    {rst_in, carrier_mode_select_in} = 2'h3;
    {cfg_wr_in, carrier_eval_done_in, signal_detected_in} = 3'h0;
    {msg_end_in, rx_error_in, rx_timeout_in} = 3'h0;
    cfg_in = 8'h00;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(negedge mclk_in);
    chk_cfg(cfg_out, 8'h00);
    $display("TB: reset values done");

    // interval and window lengths, one row per interval code 4 to 9
    foreach (rows[i]) begin
      write_cfg(rows[i].ival, rows[i].on);
      wait_start();
      chk_num(warm, 2 * DIV);
      {win, per, open} = {32'h0, 32'h0, 1'b1};
      do begin
        if (sample_window_out === 1'b1 && open) win++;
        else open = 1'b0;
        @(negedge mclk_in);
        per++;
      end while (interval_start_out !== 1'b1 && per < 20000);
      chk_num(per, rows[i].per);
      chk_num(win, rows[i].win);
      $display("TB: row %0d done", i);
    end

    // carrier mode: evaluation done cuts a 64-period window short
    write_cfg(4'h4, 4'h6);
    wait_start();
    pulse(4);
    repeat (2) @(negedge mclk_in);
    chk_num(sample_window_out, 1'b0);
    $display("TB: carrier early off done");

    // data mode: hold past the next start, released by each end event
    @(posedge mclk_in);
    carrier_mode_select_in <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      write_cfg(4'h4, 4'h0);
      wait_start();
      pulse(3);
      repeat (600) @(negedge mclk_in);
      chk_num(sample_window_out, 1'b1);
      pulse(k);
      repeat (2) @(negedge mclk_in);
      chk_num(sample_window_out, 1'b0);
      $display("TB: data hold end %0d done", k);
    end

    // continuous codes keep the detector on, with no interval start within 1500 cycles
    foreach (rows[i]) begin
      if (i > 1) break;
      write_cfg(4'hA + 4'(i * 5), 4'h0);
      repeat (2) @(negedge mclk_in);
      {hi, st} = {32'h0, 32'h0};
      repeat (1500) begin
        @(negedge mclk_in);
        if (det_power_out === 1'b1 && sample_window_out === 1'b1) hi++;
        if (interval_start_out !== 1'b0) st++;
      end
      chk_num(hi, 32'd1500);
      chk_num(st, 32'h0);
    end
    $display("TB: continuous done");

    // reset in mid-run clears the fields and powers down
    @(posedge mclk_in);
    rst_in <= 1'b1;
    @(negedge mclk_in);
    chk_cfg(cfg_out, 8'h00);
    chk_num(det_power_out, 1'b0);
    chk_num(sample_window_out, 1'b0);
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (2) @(negedge mclk_in);
    chk_num(det_power_out, 1'b0);
    chk_num(interval_start_out, 1'b0);
    $display("TB: mid-run reset done");
    print_verdict();
  end

endmodule : lfds_sched_test
